// File: clk_ctl_pkg.sv
// Constants and types shared by the sample clock control block
package clk_ctl_pkg;
  localparam logic [7:0] DIV_ALIGN_OFFSET = 8'h3A;
  localparam logic [7:0] DIV_RATIO_OFFSET = 8'h0B;
  localparam logic [7:0] POWER_OFFSET     = 8'h08;
  localparam logic [7:0] STAB_OFFSET      = 8'h09;
  localparam int         ALIGN_EVERY_BIT  = 1;
  localparam int         ALIGN_FIRST_BIT  = 2;
  localparam int         STAB_ENABLE_BIT  = 0;
  localparam logic [7:0] DIV_ALIGN_RESET  = 8'h00;
  localparam logic [7:0] DIV_RATIO_RESET  = 8'h00;
  localparam logic [7:0] POWER_RESET      = 8'h00;
  localparam logic [7:0] STAB_RESET       = 8'h01;
  localparam logic [1:0] PWR_MODE_ON      = 2'h0;
  localparam logic [1:0] PWR_MODE_DOWN    = 2'h1;
  localparam logic [1:0] PWR_MODE_STANDBY = 2'h2;
  localparam int         CLK_FREQ_MHZ     = 125;
  localparam int         STAB_MIN_MHZ     = 20;
  localparam int         WAKE_STEP_CYCLES = 4;
  localparam int         WAKE_CNT_W       = 16;
  typedef enum logic [1:0] {ALIGN_OFF, ALIGN_EVERY, ALIGN_FIRST} align_mode_t;
  typedef enum {PWR_RUN, PWR_SLEEP, PWR_WAKE} pwr_state_t;
endpackage

// File: div_if.sv
// Interface between the control logic and the divider core
`timescale 1ns/1ps
interface div_if;
  logic [2:0] ratio_m1;
  logic       realign;
  logic       run;
  logic       stab_en;
  logic       clk_en;
  logic       clk_fall;
  modport ctl  (output ratio_m1, realign, run, stab_en, input clk_en, clk_fall);
  modport core (input ratio_m1, realign, run, stab_en, output clk_en, clk_fall);
endinterface

// File: clk_div_core.sv
// Integer divider with realign and falling edge retiming
`timescale 1ns/1ps
module clk_div_core
  import clk_ctl_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  div_if.core       dv
);
  logic [2:0] cnt_r;
  logic [2:0] half;
  logic       en_r;
  logic       fall_r;

  // Mid point rounds up so a divide by two falls one cycle after the rise
  assign half = 3'(({1'b0, dv.ratio_m1} + 4'h1) >> 1);

  // Counter restarts on realign so all parts share phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 3'h0;
    end else if (dv.realign || !dv.run) begin // [RULE3]
      cnt_r <= 3'h0;
    end else if (cnt_r >= dv.ratio_m1) begin // [RULE1] [RULE16]
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // One enable per N input cycles; ratio one gives enable every cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r <= 1'b0;
    end else begin
      en_r <= dv.run && !dv.realign && (cnt_r == 3'h0); // [RULE16]
    end
  end

  // Falling edge placed at mid period instead of following the input
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fall_r <= 1'b0;
    end else begin
      fall_r <= dv.run && dv.stab_en && !dv.realign && (cnt_r == half); // [RULE6]
    end
  end

  assign dv.clk_en   = en_r;
  assign dv.clk_fall = fall_r;

  a_div_period: assert property (@(posedge clk) disable iff (!reset_n) // [RULE16]
    (dv.ratio_m1 == 3'h1 && $stable(dv.ratio_m1) && dv.run && !dv.realign && en_r)
      |=> !en_r)
    else $error("Divide by two enable came twice in a row");
endmodule

// File: sample_clock_control.sv
// Sample clock divider, alignment, stabilizer and power control
`timescale 1ns/1ps
// What this block does
// RULE1 - Divides the input sample clock by an integer ratio from one to eight.
// RULE2 - Divider_align_control bits pick realign on every pulse or first pulse only.
// RULE3 - An accepted alignment pulse returns the divider counter to its start.
// RULE4 - Alignment pulse passes an internal synchronizer on the sample clock.
// RULE5 - Far side drives alignment pulse synchronous to the sample clock.
// RULE6 - Stabilizer enabled regenerates the falling edge for fifty percent duty.
// RULE7 - Stabilizer need not work below about 20 MHz clock rate.
// RULE8 - User waits 1.5 to 5 us after clock rate change for relock.
// RULE9 - Power-down when pin is high or serial port commands it.
// RULE10 - In power-down every output driver goes high impedance.
// RULE11 - Pin driven low returns the device to normal operation.
// RULE12 - Power-down stops reference, bias and clock; wake time tracks sleep time.
// RULE13 - Serial standby keeps the reference on for faster wake-up.
// RULE14 - Reference select tied to supply disables the internal reference.
// RULE15 - Settings live in byte registers that can be written and read back.
// RULE16 - Ratio N gives one internal clock per N inputs; one passes through.
// RULE17 - First-pulse mode ignores later pulses until control is rewritten.
module sample_clock_control
  import clk_ctl_pkg::*;
#(
  parameter int WAKE_STEP = WAKE_STEP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       align_pulse,
  input  wire logic       power_down_pin,
  input  wire logic       ref_sel_analog_supply,
  input  wire logic       stab_rate_ok,
  output logic            int_clk_en,
  output logic            int_clk_fall,
  output logic            ref_on,
  output logic            ref_internal,
  output logic            bias_on,
  output logic            awake,
  output logic            out_drv_oe
);
  div_if dv ();

  logic [7:0]        align_ctl_r;
  logic [7:0]        ratio_r;
  logic [7:0]        power_r;
  logic [7:0]        stab_r;
  logic              standby_r;
  logic [2:0]        sync_r;
  logic              sync_prev_r;
  logic              pulse_rise;
  logic              align_done_r;
  logic              align_take;
  logic [2:0]        pin_r;
  logic              pin_q_r;
  logic [2:0]        refs_r;
  logic              refs_q_r;
  logic              want_down;
  logic              want_standby;
  pwr_state_t        pwr_r;
  logic [WAKE_CNT_W-1:0] sleep_cnt_r;
  logic [WAKE_CNT_W-1:0] wake_cnt_r;
  logic [7:0]        rdata_r;
  align_mode_t       mode;

  // Serial port register file, byte wide, read back
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      align_ctl_r <= DIV_ALIGN_RESET;
      ratio_r     <= DIV_RATIO_RESET;
      power_r     <= POWER_RESET;
      stab_r      <= STAB_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        DIV_ALIGN_OFFSET: align_ctl_r <= {5'h00, reg_wdata[2:1], 1'b0}; // [RULE15]
        DIV_RATIO_OFFSET: ratio_r     <= {5'h00, reg_wdata[2:0]}; // [RULE15]
        POWER_OFFSET:     power_r     <= {6'h00, reg_wdata[1:0]}; // [RULE15]
        STAB_OFFSET:      stab_r      <= {7'h00, reg_wdata[0]}; // [RULE15]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        DIV_ALIGN_OFFSET: rdata_r <= align_ctl_r; // [RULE15]
        DIV_RATIO_OFFSET: rdata_r <= ratio_r;
        POWER_OFFSET:     rdata_r <= power_r;
        STAB_OFFSET:      rdata_r <= stab_r;
        default:          rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_r;

  always_comb begin
    if (align_ctl_r[ALIGN_EVERY_BIT]) begin
      mode = ALIGN_EVERY;
    end else if (align_ctl_r[ALIGN_FIRST_BIT]) begin
      mode = ALIGN_FIRST;
    end else begin
      mode = ALIGN_OFF;
    end
  end

  // Three stage synchronizer; pulse counts when stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_r      <= 3'h0;
      sync_prev_r <= 1'b0;
    end else begin
      sync_r      <= {sync_r[1:0], align_pulse}; // [RULE4]
      if (sync_r[2] == sync_r[1]) begin
        sync_prev_r <= sync_r[2];
      end
    end
  end
  assign pulse_rise = (sync_r[2] == sync_r[1]) && sync_r[2] && !sync_prev_r; // [RULE4] [RULE5]

  assign align_take = pulse_rise && (mode == ALIGN_EVERY ||
                      (mode == ALIGN_FIRST && !align_done_r)); // [RULE2]

  // Write to the control register rearms first-pulse mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      align_done_r <= 1'b0;
    end else if (align_take && mode == ALIGN_FIRST) begin
      align_done_r <= 1'b1; // [RULE17]
    end else if (reg_wr && reg_addr == DIV_ALIGN_OFFSET) begin
      align_done_r <= 1'b0; // [RULE17]
    end
  end

  // Power pins through the same three stage filter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_r    <= 3'h0;
      pin_q_r  <= 1'b0;
      refs_r   <= 3'h0;
      refs_q_r <= 1'b0;
    end else begin
      pin_r  <= {pin_r[1:0], power_down_pin};
      refs_r <= {refs_r[1:0], ref_sel_analog_supply};
      if (pin_r[2] == pin_r[1]) begin
        pin_q_r <= pin_r[2];
      end
      if (refs_r[2] == refs_r[1]) begin
        refs_q_r <= refs_r[2];
      end
    end
  end

  assign want_down    = pin_q_r || (power_r[1:0] == PWR_MODE_DOWN); // [RULE9] [RULE11]
  assign want_standby = !want_down && (power_r[1:0] == PWR_MODE_STANDBY); // [RULE13]

  // Wake delay grows with time spent asleep, as capacitors recharge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_r       <= PWR_RUN;
      sleep_cnt_r <= '0;
      wake_cnt_r  <= '0;
    end else begin
      case (pwr_r)
        PWR_RUN: begin
          sleep_cnt_r <= '0;
          if (want_down || want_standby) begin
            pwr_r <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (sleep_cnt_r != '1) begin
            sleep_cnt_r <= sleep_cnt_r + 1'b1;
          end
          if (!want_down && !want_standby) begin
            pwr_r      <= PWR_WAKE;
            // Standby flag lags a cycle, so it survives the write that ends standby
            wake_cnt_r <= standby_r ?
                          (sleep_cnt_r >> 2) / WAKE_CNT_W'(WAKE_STEP) :
                          sleep_cnt_r / WAKE_CNT_W'(WAKE_STEP); // [RULE12] [RULE13]
          end
        end
        PWR_WAKE: begin
          if (want_down || want_standby) begin
            pwr_r <= PWR_SLEEP;
          end else if (wake_cnt_r == '0) begin
            pwr_r <= PWR_RUN;
          end else begin
            wake_cnt_r <= wake_cnt_r - 1'b1;
          end
        end
        default: pwr_r <= PWR_RUN;
      endcase
    end
  end

  // Standby leaves the reference up; external select turns internal one off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      standby_r <= 1'b0;
    end else begin
      standby_r <= want_standby;
    end
  end

  assign awake        = (pwr_r == PWR_RUN);
  assign bias_on      = (pwr_r != PWR_SLEEP); // [RULE12]
  assign ref_on       = (pwr_r != PWR_SLEEP) || standby_r; // [RULE12] [RULE13]
  assign ref_internal = ref_on && !refs_q_r; // [RULE14]
  assign out_drv_oe   = awake && !want_down; // [RULE10]

  // Stabilizer only honoured when the rate is high enough to lock
  assign dv.ratio_m1 = ratio_r[2:0]; // [RULE1]
  assign dv.realign  = align_take; // [RULE3]
  assign dv.run      = (pwr_r != PWR_SLEEP); // [RULE12]
  assign dv.stab_en  = stab_r[STAB_ENABLE_BIT] && stab_rate_ok; // [RULE6] [RULE7]

  clk_div_core u_core (
    .clk     (clk),
    .reset_n (reset_n),
    .dv      (dv)
  );

  assign int_clk_en   = dv.clk_en;
  assign int_clk_fall = dv.clk_fall;

  a_first_once: assert property (@(posedge clk) disable iff (!reset_n) // [RULE17]
    (mode == ALIGN_FIRST && align_done_r && !(reg_wr && reg_addr == DIV_ALIGN_OFFSET))
      |-> !align_take)
    else $error("Second pulse accepted in first-pulse mode");
  a_every_take: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
    (mode == ALIGN_EVERY && pulse_rise) |-> align_take)
    else $error("Pulse dropped in every-pulse mode");
  a_realign_phase: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
    (align_take && pwr_r != PWR_SLEEP) |=> !int_clk_en ##1 int_clk_en)
    else $error("Divider did not restart after alignment");
  a_sync_delay: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
    pulse_rise |-> $past(align_pulse, 3))
    else $error("Alignment pulse skipped the synchronizer");
  a_pin_down: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9] [RULE10]
    pin_q_r |=> !out_drv_oe)
    else $error("Outputs driven during power-down");
  // Clock enable is registered, so it may still stand in the first sleep cycle
  a_sleep_off: assert property (@(posedge clk) disable iff (!reset_n) // [RULE12]
    (pwr_r == PWR_SLEEP) |-> !bias_on && ($past(pwr_r) != PWR_SLEEP || !int_clk_en))
    else $error("Bias or clock alive in power-down");
  a_standby_ref: assert property (@(posedge clk) disable iff (!reset_n) // [RULE13]
    (pwr_r == PWR_SLEEP && standby_r) |-> ref_on)
    else $error("Reference off in standby");
  a_ext_ref: assert property (@(posedge clk) disable iff (!reset_n) // [RULE14]
    refs_q_r |-> !ref_internal)
    else $error("Internal reference on with external select");
  a_pass_thru: assert property (@(posedge clk) disable iff (!reset_n) // [RULE16]
    (ratio_r[2:0] == 3'h0 && awake && !align_take)[*2] |=> int_clk_en)
    else $error("Ratio one did not pass every cycle");
  a_pin_wake: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
    (pwr_r == PWR_WAKE && !want_down && !want_standby && wake_cnt_r == '0)
      |=> awake)
    else $error("Wake did not return to run");

  c_first_align: cover property (@(posedge clk) disable iff (!reset_n)
    mode == ALIGN_FIRST && align_take);
  c_every_align: cover property (@(posedge clk) disable iff (!reset_n)
    mode == ALIGN_EVERY && align_take);
  c_wake_up: cover property (@(posedge clk) disable iff (!reset_n)
    pwr_r == PWR_WAKE ##1 pwr_r == PWR_RUN);
  c_stab_fall: cover property (@(posedge clk) disable iff (!reset_n) int_clk_fall);
endmodule

// File: align_driver.sv
// Far-side alignment pulse source
`timescale 1ns/1ps
module align_driver (
  input  wire logic clk,
  input  wire logic fire,
  output logic      align_pulse
);
  initial align_pulse = 1'b0;
  // Launched on the sample clock so every device sees one edge
  always @(posedge clk) begin
    align_pulse <= fire;
  end
endmodule

// File: sample_clock_control_tb.sv
// Self-checking bench for the sample clock control block
`timescale 1ns/1ps
module sample_clock_control_tb;
  import clk_ctl_pkg::*;
  logic       clk       = 1'b0;
  logic       reset_n   = 1'b0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       fire      = 1'b0;
  logic       align_pulse;
  logic       pd_pin    = 1'b0;
  logic       ref_sel   = 1'b0;
  logic       rate_ok   = 1'b1;
  logic       en, fall, ref_on, ref_int, bias_on, awake, oe;
  int         bad_count = 0;
  int         n_checks  = 0;
  int         a, b;

  always #4 clk = ~clk;

  align_driver drv_u (.clk(clk), .fire(fire), .align_pulse(align_pulse));

  // Wake step of one makes the wake count equal the sleep count, or a quarter of it after standby
  sample_clock_control #(.WAKE_STEP(1)) dut_u (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .align_pulse(align_pulse), .power_down_pin(pd_pin),
    .ref_sel_analog_supply(ref_sel), .stab_rate_ok(rate_ok),
    .int_clk_en(en), .int_clk_fall(fall), .ref_on(ref_on),
    .ref_internal(ref_int), .bias_on(bias_on), .awake(awake), .out_drv_oe(oe)
  );

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t %s %h", $time, m, got);
    end
  endtask

  task automatic chk_int(input int got, input int exp, input string m);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch %0t %s %0d", $time, m, got);
    end
  endtask

  // Outputs are read at the falling edge, clear of the launching edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk_byte(reg_rdata, exp, "readback");
  endtask

  task automatic reg_test;
    rd_chk(DIV_ALIGN_OFFSET, DIV_ALIGN_RESET);
    rd_chk(DIV_RATIO_OFFSET, DIV_RATIO_RESET);
    rd_chk(POWER_OFFSET, POWER_RESET);
    rd_chk(STAB_OFFSET, STAB_RESET);
    rd_chk(8'hFF, 8'h00);
    wr(DIV_RATIO_OFFSET, 8'hFF);
    rd_chk(DIV_RATIO_OFFSET, 8'h07);
    wr(DIV_ALIGN_OFFSET, 8'hFF);
    rd_chk(DIV_ALIGN_OFFSET, 8'h06);
  endtask

  // 840 is a multiple of every ratio, so the count is phase independent
  task automatic ratio_cnt(input int n);
    int k;
    wr(DIV_RATIO_OFFSET, 8'(n - 1));
    cyc(20);
    k = 0;
    repeat (840) begin
      @(negedge clk);
      if (en === 1'b1) k++;
    end
    chk_int(k, 840 / n, "ratio");
  endtask

  task automatic pulse_phase(output int ph);
    int c;
    @(posedge clk);
    fire <= 1'b1;
    // Two cycles wide so stages two and three of the synchronizer agree
    repeat (2) @(posedge clk);
    fire <= 1'b0;
    c = 0;
    while ((c < 16 || en !== 1'b1) && c < 40) begin
      @(negedge clk);
      c++;
    end
    ph = c % 8;
  endtask

  // A gap of four leaves an ignored pulse well off the realigned phase
  task automatic align_test;
    wr(DIV_RATIO_OFFSET, 8'h07);
    wr(DIV_ALIGN_OFFSET, 8'h02);
    pulse_phase(a);
    cyc(4);
    pulse_phase(b);
    chk_int(b, a, "every");
    wr(DIV_ALIGN_OFFSET, 8'h04);
    pulse_phase(a);
    cyc(4);
    pulse_phase(b);
    chk_bit(1'(a != b), 1'b1, "first");
    wr(DIV_ALIGN_OFFSET, 8'h04);
    cyc(4);
    pulse_phase(b);
    chk_int(b, a, "rearm");
  endtask

  task automatic fall_at(input logic exp);
    int c;
    cyc(4);
    c = 0;
    while (en !== 1'b1 && c < 16) begin
      @(negedge clk);
      c++;
    end
    cyc(1);
    chk_bit(fall, 1'b0, "fall early");
    cyc(1);
    chk_bit(fall, exp, "fall mid");
  endtask

  task automatic stab_test;
    wr(DIV_RATIO_OFFSET, 8'h03);
    fall_at(1'b1);
    wr(STAB_OFFSET, 8'h00);
    fall_at(1'b0);
    wr(STAB_OFFSET, 8'h01);
    @(posedge clk);
    rate_ok <= 1'b0;
    fall_at(1'b0);
    @(posedge clk);
    rate_ok <= 1'b1;
    cyc(200); // Relock wait after a rate change
    fall_at(1'b1);
  endtask

  task automatic sleep_wake(input int mode, input int dur, output int w);
    if (mode == 0) begin
      @(posedge clk);
      pd_pin <= 1'b1;
    end else begin
      wr(POWER_OFFSET, 8'(mode));
    end
    cyc(dur);
    chk_bit(awake, 1'b0, "awake");
    chk_bit(oe, 1'b0, "oe");
    chk_bit(bias_on | en, 1'b0, "bias clk");
    chk_bit(ref_on, 1'(mode == 2), "ref");
    if (mode == 0) begin
      @(posedge clk);
      pd_pin <= 1'b0;
    end else begin
      wr(POWER_OFFSET, 8'h00);
    end
    w = 0;
    while (awake !== 1'b1 && w < 1000) begin
      @(negedge clk);
      w++;
    end
    chk_bit(oe, 1'b1, "wake");
  endtask

  task automatic power_test;
    sleep_wake(0, 20, a);
    sleep_wake(0, 200, b);
    chk_bit(1'(b > a), 1'b1, "wake grows");
    sleep_wake(1, 200, a);
    sleep_wake(2, 200, b);
    chk_bit(1'(b < a), 1'b1, "standby");
    @(posedge clk);
    ref_sel <= 1'b1;
    cyc(8);
    chk_bit(ref_int, 1'b0, "ext ref");
    @(posedge clk);
    ref_sel <= 1'b0;
    cyc(8);
    chk_bit(ref_int, 1'b1, "int ref");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    reg_test;
    for (int n = 1; n <= 8; n++) begin
      ratio_cnt(n);
    end
    align_test;
    stab_test;
    power_test;
    complete_run;
  end

  // Whole run is a little under nine thousand cycles
  initial begin
    #400000;
    bad_count++;
    $display("mismatch %0t watchdog", $time);
    complete_run;
  end
endmodule
